// >>> src/fsis_regs.vh
// Purpose: Shared constants for the frame-sync input selection block.
// Assumes: A single master clock with a 25 ns period.
// Notes: Times are in nanoseconds; cycle counts stand beside the times they come from.
`ifndef FSIS_REGS_VH
`define FSIS_REGS_VH

// Master clock period, 40 MHz.
`define FSIS_MCLK_NS 25
// Local oscillator and master multiplier, kept for reference by the clock plan.
`define FSIS_LOCAL_OSC_KHZ 12800
`define FSIS_MCLK_MULT 16

// Nominal frame-sync periods for 2 kHz, 4 kHz and 8 kHz.
`define FSIS_T_2K_NS 500000
`define FSIS_T_4K_NS 250000
`define FSIS_T_8K_NS 125000
// The same periods in master clock cycles at 25 ns per cycle.
`define FSIS_2K_CYC 16'h4E20
`define FSIS_4K_CYC 16'h2710
`define FSIS_8K_CYC 16'h1388

// Width of the period counter; it saturates at all ones.
`define FSIS_CNT_W 16
`define FSIS_CNT_MAX 16'hFFFF

// Detected frame-sync rate codes.
`define FSIS_RATE_NONE 2'h0
`define FSIS_RATE_2K 2'h1
`define FSIS_RATE_4K 2'h2
`define FSIS_RATE_8K 2'h3

// Expected-frequency codes for the reference inputs.
`define FSIS_FREQ_8K 4'h0
`define FSIS_FREQ_19M44 4'h1

// Frame-sync origin field: the top two bits set select the paired mode.
`define FSIS_ORIGIN_PAIRED 2'h3

// Pair choice values: force pin a, b or c, or follow the selected reference.
`define FSIS_PAIR_A 2'h0
`define FSIS_PAIR_B 2'h1
`define FSIS_PAIR_C 2'h2
`define FSIS_PAIR_AUTO 2'h3

// Reference input numbers; zero means no input.
`define FSIS_REF_NONE 4'h0
`define FSIS_REF_2 4'h2
`define FSIS_REF_3 4'h3
`define FSIS_REF_4 4'h4
`define FSIS_REF_5 4'h5
`define FSIS_REF_6 4'h6
`define FSIS_REF_9 4'h9

`endif

// >>> src/fsis_pin.v
// Purpose: Synchronise one frame-sync pin, find rising edges and classify the rate.
// Assumes: The pin is asynchronous to i_mclk.
// Notes: The rate is judged from one full period, within a tolerance of 1/16.
`timescale 1ns/1ps
`include "fsis_regs.vh"

module fsis_pin #(
    parameter [15:0] P_2K_CYC = `FSIS_2K_CYC,
    parameter [15:0] P_4K_CYC = `FSIS_4K_CYC,
    parameter [15:0] P_8K_CYC = `FSIS_8K_CYC,
    // Level at which the pin rests on its pull resistor.
    parameter [0:0] P_IDLE = 1'b0
) (
    input wire i_mclk,
    input wire i_rst,
    input wire i_pin,
    output wire o_edge,
    output wire [1:0] o_rate
);

    reg meta_q;
    reg sync_q;
    reg prev_q;
    reg edge_q;
    reg [15:0] cnt_q;
    reg [1:0] rate_q;

    function near;
        input [15:0] cnt;
        input [15:0] nom;
        begin
            near = (cnt >= nom - (nom >> 4)) && (cnt <= nom + (nom >> 4));
        end
    endfunction

    function [1:0] classify;
        input [15:0] cnt;
        begin
            if (near(cnt, P_2K_CYC)) begin
                classify = `FSIS_RATE_2K;
            end else if (near(cnt, P_4K_CYC)) begin
                classify = `FSIS_RATE_4K;
            end else if (near(cnt, P_8K_CYC)) begin
                classify = `FSIS_RATE_8K;
            end else begin
                classify = `FSIS_RATE_NONE;
            end
        end
    endfunction

    always @(posedge i_mclk) begin
        if (i_rst) begin
            // Starting at the idle level keeps reset from faking a rising edge.
            meta_q <= P_IDLE;
            sync_q <= P_IDLE;
            prev_q <= P_IDLE;
            edge_q <= 1'b0;
            cnt_q <= 16'h0000;
            rate_q <= `FSIS_RATE_NONE;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
            edge_q <= sync_q & ~prev_q;
            if (sync_q & ~prev_q) begin
                // Counter holds cycles since the last edge, so add one for the period.
                rate_q <= classify(cnt_q + 16'h0001);
                cnt_q <= 16'h0000;
            end else if (cnt_q != `FSIS_CNT_MAX) begin
                cnt_q <= cnt_q + 16'h0001;
            end else begin
                // A stalled pin cannot keep a stale rate alive.
                rate_q <= `FSIS_RATE_NONE;
            end
        end
    end

    assign o_edge = edge_q;
    assign o_rate = rate_q;

endmodule // fsis_pin

// >>> src/fsis_top.v
// Purpose: Route three frame-sync pins to the reference inputs and hold expected rates.
// Assumes: i_mclk is the master clock formed from the local oscillator.
// Notes: Configuration arrives on plain ports; there is no software register bus.
`timescale 1ns/1ps
`include "fsis_regs.vh"

module fsis_top #(
    // Frame-sync periods in master clock cycles; shorten for simulation.
    parameter [15:0] P_2K_CYC = `FSIS_2K_CYC,
    parameter [15:0] P_4K_CYC = `FSIS_4K_CYC,
    parameter [15:0] P_8K_CYC = `FSIS_8K_CYC
) (
    input wire i_mclk,
    input wire i_rst,
    // Frame-sync pins, asynchronous.
    input wire i_frame_pulse_in_a,
    input wire i_frame_pulse_in_b,
    input wire i_frame_pulse_in_c,
    // Routing configuration, from logic on i_mclk.
    input wire [3:0] i_sync_origin_select,
    input wire [1:0] i_sync_pair_choice,
    input wire [3:0] i_selected_ref,
    // Expected-frequency write port; slot 0..7 stands for inputs 1,2,3,4,5,6,8,9.
    input wire i_freq_we,
    input wire [2:0] i_freq_slot,
    input wire [3:0] i_freq_code,
    // Routed frame sync.
    output wire o_ext_sync,
    output wire [3:0] o_sync_ref,
    output wire o_sync_on_selected,
    output wire [1:0] o_sync_rate,
    output wire [2:0] o_pin_active,
    // Expected frequency codes, slot 0 in the low nibble.
    output wire [31:0] o_exp_freq
);

    wire [2:0] pin_raw;
    wire [2:0] pin_edge;
    wire [5:0] pin_rate;

    reg ext_sync_q;
    reg [3:0] sync_ref_q;
    reg on_sel_q;
    reg [1:0] sync_rate_q;
    reg [2:0] pin_active_q;
    reg [31:0] freq_q;

    reg [2:0] pin_active_d;
    reg [3:0] sync_ref_d;
    reg [1:0] pin_idx;

    wire paired;
    wire [3:0] ref_a;
    wire [3:0] ref_b;
    wire [3:0] ref_c;

    assign pin_raw = {i_frame_pulse_in_c, i_frame_pulse_in_b, i_frame_pulse_in_a};

    // Every pin logic runs on the single master clock.
    // Pin c rests high on its pull-up while a and b rest low.
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_pin
            fsis_pin #(
                .P_2K_CYC(P_2K_CYC),
                .P_4K_CYC(P_4K_CYC),
                .P_8K_CYC(P_8K_CYC),
                .P_IDLE(g == 2)
            ) u_pin (
                .i_mclk(i_mclk),
                .i_rst(i_rst),
                .i_pin(pin_raw[g]),
                .o_edge(pin_edge[g]),
                .o_rate(pin_rate[2*g+1:2*g])
            );
        end
    endgenerate

    // Of a pair, the member that is currently selected wins; otherwise the first.
    function [3:0] pick;
        input [3:0] sel;
        input [3:0] first;
        input [3:0] second;
        begin
            if (sel == second) begin
                pick = second;
            end else begin
                pick = first;
            end
        end
    endfunction

    function in_pair;
        input [3:0] sel;
        input [3:0] first;
        input [3:0] second;
        begin
            in_pair = (sel == first) || (sel == second);
        end
    endfunction

    assign paired = (i_sync_origin_select[3:2] == `FSIS_ORIGIN_PAIRED);
    assign ref_a = pick(i_selected_ref, `FSIS_REF_3, `FSIS_REF_5);
    assign ref_b = pick(i_selected_ref, `FSIS_REF_4, `FSIS_REF_6);
    assign ref_c = pick(i_selected_ref, `FSIS_REF_9, `FSIS_REF_2);

    always @* begin
        pin_active_d = 3'b000;
        sync_ref_d = `FSIS_REF_NONE;
        pin_idx = 2'h0;
        if (!paired) begin
            // Only pin a can serve; b and c never reach the output here.
            if (i_sync_origin_select != `FSIS_REF_NONE) begin
                pin_active_d = 3'b001;
                sync_ref_d = i_sync_origin_select;
            end
        end else begin
            case (i_sync_pair_choice)
                `FSIS_PAIR_A: begin
                    pin_idx = 2'h0;
                end
                `FSIS_PAIR_B: begin
                    pin_idx = 2'h1;
                end
                `FSIS_PAIR_C: begin
                    pin_idx = 2'h2;
                end
                default: begin
                    // Follow the selected reference; no pair holds it means no pin.
                    if (in_pair(i_selected_ref, `FSIS_REF_3, `FSIS_REF_5)) begin
                        pin_idx = 2'h0;
                    end else if (in_pair(i_selected_ref, `FSIS_REF_4, `FSIS_REF_6)) begin
                        pin_idx = 2'h1;
                    end else if (in_pair(i_selected_ref, `FSIS_REF_9, `FSIS_REF_2)) begin
                        pin_idx = 2'h2;
                    end else begin
                        pin_idx = 2'h3;
                    end
                end
            endcase
            case (pin_idx)
                2'h0: begin
                    pin_active_d = 3'b001;
                    sync_ref_d = ref_a;
                end
                2'h1: begin
                    pin_active_d = 3'b010;
                    sync_ref_d = ref_b;
                end
                2'h2: begin
                    pin_active_d = 3'b100;
                    sync_ref_d = ref_c;
                end
                default: begin
                    pin_active_d = 3'b000;
                    sync_ref_d = `FSIS_REF_NONE;
                end
            endcase
        end
    end

    // Default code for a slot: slots 0 to 3 are inputs 1 to 4 at 8 kHz, the rest 19.44 MHz.
    function [3:0] slot_default;
        input [2:0] slot;
        begin
            if (slot < 3'h4) begin
                slot_default = `FSIS_FREQ_8K;
            end else begin
                slot_default = `FSIS_FREQ_19M44;
            end
        end
    endfunction

    always @(posedge i_mclk) begin
        if (i_rst) begin
            ext_sync_q <= 1'b0;
            sync_ref_q <= `FSIS_REF_NONE;
            on_sel_q <= 1'b0;
            sync_rate_q <= `FSIS_RATE_NONE;
            pin_active_q <= 3'b000;
            freq_q <= {slot_default(3'h7), slot_default(3'h6), slot_default(3'h5),
                slot_default(3'h4), slot_default(3'h3), slot_default(3'h2),
                slot_default(3'h1), slot_default(3'h0)};
        end else begin
            pin_active_q <= pin_active_d;
            sync_ref_q <= sync_ref_d;
            on_sel_q <= (sync_ref_d != `FSIS_REF_NONE) && (sync_ref_d == i_selected_ref);
            // Masking by the active pin keeps unused pins off the output.
            ext_sync_q <= |(pin_edge & pin_active_d);
            if (pin_active_d[0]) begin
                sync_rate_q <= pin_rate[1:0];
            end else if (pin_active_d[1]) begin
                sync_rate_q <= pin_rate[3:2];
            end else if (pin_active_d[2]) begin
                sync_rate_q <= pin_rate[5:4];
            end else begin
                sync_rate_q <= `FSIS_RATE_NONE;
            end
            if (i_freq_we) begin
                // Slots are programmable after reset.
                freq_q[{i_freq_slot, 2'b00} +: 4] <= i_freq_code;
            end
        end
    end

    assign o_ext_sync = ext_sync_q;
    assign o_sync_ref = sync_ref_q;
    assign o_sync_on_selected = on_sel_q;
    assign o_sync_rate = sync_rate_q;
    assign o_pin_active = pin_active_q;
    assign o_exp_freq = freq_q;

endmodule // fsis_top

// >>> verification/fsis_top_asserts.sv
// Purpose: Port-level assertions for the frame-sync routing block.
// Assumes: Pin traffic runs only while the routing stays put.
// Notes: Bound into fsis_top below.
`timescale 1ns/1ps
module fsis_top_asserts (
    input wire i_mclk,
    input wire i_rst,
    input wire [3:0] i_sync_origin_select,
    input wire [1:0] i_sync_pair_choice,
    input wire [3:0] i_selected_ref,
    input wire i_freq_we,
    input wire [2:0] i_freq_slot,
    input wire [3:0] i_freq_code,
    input wire o_ext_sync,
    input wire [3:0] o_sync_ref,
    input wire [2:0] o_pin_active,
    input wire [31:0] o_exp_freq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    wire pr = i_sync_origin_select[3:2] == 2'h3;
    wire [1:0] ch = i_sync_pair_choice;
    wire [3:0] sl = i_selected_ref;
    chk_direct_ref: assert property (!pr && i_sync_origin_select != 4'h0 |=>
        o_sync_ref == $past(i_sync_origin_select) && o_pin_active == 3'h1) else $error("direct");
    chk_bc_ignored: assert property (!pr |=> o_pin_active[2:1] == 2'h0)
        else $error("b or c routed");
    chk_pin_a_pair: assert property (pr && ch == 2'h0 |=> o_pin_active == 3'h1 &&
        o_sync_ref == (($past(sl) == 4'h5) ? 4'h5 : 4'h3)) else $error("pin a pair");
    chk_pin_b_pair: assert property (pr && ch == 2'h1 |=> o_pin_active == 3'h2 &&
        o_sync_ref == (($past(sl) == 4'h6) ? 4'h6 : 4'h4)) else $error("pin b pair");
    chk_pin_c_pair: assert property (pr && ch == 2'h2 |=> o_pin_active == 3'h4 &&
        o_sync_ref == (($past(sl) == 4'h2) ? 4'h2 : 4'h9)) else $error("pin c pair");
    chk_auto_follow: assert property (pr && ch == 2'h3 && sl inside {2, 3, 4, 5, 6, 9}
        |=> o_sync_ref == $past(sl)) else $error("auto follow");
    chk_sync_pulse: assert property (o_ext_sync |=> !o_ext_sync) else $error("long pulse");
    chk_freq_write: assert property (i_freq_we |=>
        ((o_exp_freq >> {$past(i_freq_slot), 2'h0}) & 32'hF) == {28'h0, $past(i_freq_code)})
        else $error("freq write");
    chk_reset_freq: assert property ($past(i_rst) |-> o_exp_freq == 32'h11110000)
        else $error("freq reset");
    cover property (o_ext_sync);
    cover property (pr && ch == 2'h3 ##1 o_pin_active == 3'h4);
    cover property (i_freq_we ##1 i_freq_we);
endmodule // fsis_top_asserts

bind fsis_top fsis_top_asserts u_chk (.i_mclk, .i_rst, .i_sync_origin_select,
    .i_sync_pair_choice, .i_selected_ref, .i_freq_we, .i_freq_slot, .i_freq_code,
    .o_ext_sync, .o_sync_ref, .o_pin_active, .o_exp_freq);

// >>> verification/fsis_sync_src.sv
// Purpose: Line-side model driving the three frame-sync pins.
// Assumes: Periods are given in master clock cycles.
// Notes: An idle pin falls to its pull level, so no stale level hides a fault.
`timescale 1ns/1ps
module fsis_sync_src #(
    parameter P2 = 400,
    parameter P4 = 200,
    parameter P8 = 100
) (
    input wire i_mclk,
    input wire [5:0] i_rates,
    output reg [2:0] o_pins
);
    integer n [0:2];
    integer k;
    integer p;
    initial begin
        for (k = 0; k < 3; k = k + 1) n[k] = 0;
        o_pins = 3'h4;
    end
    // Driven on the falling edge to sit apart from the block's sampling edge.
    always @(negedge i_mclk) begin
        for (k = 0; k < 3; k = k + 1) begin
            case (i_rates[2 * k +: 2])
                2'h1: p = P2;
                2'h2: p = P4;
                2'h3: p = P8;
                default: p = 0;
            endcase
            if (p == 0) begin
                n[k] = 0;
                o_pins[k] <= (k == 2);
            end else begin
                n[k] = (n[k] + 1) % p;
                o_pins[k] <= (n[k] < 4);
            end
        end
    end
endmodule // fsis_sync_src

// >>> verification/fsis_top_test.sv
// Purpose: Self-checking bench for the frame-sync routing block.
// Assumes: Shortened frame periods of 400, 200 and 100 cycles.
// Notes: Routing is swept exhaustively; rates and codes come from xorshift.
`timescale 1ns/1ps
module fsis_top_test;
    localparam P2 = 400;
    reg mclk = 0, rst = 1, we = 0;
    reg [3:0] org = 0, sel = 0, code = 0;
    reg [1:0] ch = 0;
    reg [2:0] slot = 0;
    reg [5:0] rates = 0, rt;
    reg [6:0] r;
    reg [31:0] seed = 32'h14, fexp;
    wire [2:0] pins, act;
    wire ext, onsel;
    wire [3:0] sref;
    wire [1:0] srate;
    wire [31:0] freq;
    integer mismatches = 0, n_tests = 0, i, k, q, e, cnt;
    initial forever #12.5 mclk = ~mclk;
    fsis_top #(.P_2K_CYC(16'd400), .P_4K_CYC(16'd200), .P_8K_CYC(16'd100)) DUT (
        .i_mclk(mclk), .i_rst(rst), .i_frame_pulse_in_a(pins[0]),
        .i_frame_pulse_in_b(pins[1]), .i_frame_pulse_in_c(pins[2]),
        .i_sync_origin_select(org), .i_sync_pair_choice(ch), .i_selected_ref(sel),
        .i_freq_we(we), .i_freq_slot(slot), .i_freq_code(code), .o_ext_sync(ext),
        .o_sync_ref(sref), .o_sync_on_selected(onsel), .o_sync_rate(srate),
        .o_pin_active(act), .o_exp_freq(freq));
    fsis_sync_src u_src (
        .i_mclk(mclk), .i_rates(rates), .o_pins(pins));
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    function [6:0] route(input [3:0] o, input [1:0] c, input [3:0] s);
        begin
            route = 7'h0;
            if (o[3:2] != 2'h3) route = {2'h0, o != 4'h0, o};
            else if (c == 2'h0 || (c == 2'h3 && (s == 4'h3 || s == 4'h5)))
                route = {3'h1, ((s == 4'h5) ? 4'h5 : 4'h3)};
            else if (c == 2'h1 || (c == 2'h3 && (s == 4'h4 || s == 4'h6)))
                route = {3'h2, ((s == 4'h6) ? 4'h6 : 4'h4)};
            else if (c == 2'h2 || (c == 2'h3 && (s == 4'h9 || s == 4'h2)))
                route = {3'h4, ((s == 4'h2) ? 4'h2 : 4'h9)};
        end
    endfunction
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("wrong value %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    task pulses(input integer lo, input integer hi);
        begin
            cnt = 0;
            repeat (2 * P2) begin
                @(posedge mclk);
                #1 cnt = cnt + ext;
            end
            check("pulse count", (cnt >= lo && cnt <= hi), 1);
        end
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1 check("exp_freq", freq, 32'h11110000);
        check("idle", {act, sref}, 0);
        // Pin c rests high after reset; routing it must not show a phantom edge.
        @(posedge mclk);
        org <= 4'hC;
        ch <= 2'h2;
        pulses(0, 0);
        fexp = 32'h11110000;
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            @(posedge mclk);
            we <= 1'b1;
            slot <= i[2:0];
            code <= seed[3:0];
            fexp[4 * i +: 4] = seed[3:0];
        end
        @(posedge mclk);
        we <= 1'b0;
        @(posedge mclk);
        #1 check("exp_freq", freq, fexp);
        for (i = 0; i < 1024; i = i + 1) begin
            @(posedge mclk);
            org <= i[3:0];
            ch <= i[5:4];
            sel <= i[9:6];
            r = route(i[3:0], i[5:4], i[9:6]);
            repeat (2) @(posedge mclk);
            #1 check("route", {act, sref}, r);
            check("on_sel", onsel, r[3:0] == i[9:6] && r[3:0] != 4'h0);
        end
        for (i = 0; i < 9; i = i + 1) begin
            k = i % 3;
            q = i / 3 + 1;
            e = 2 << (i / 3);
            seed = xs(seed);
            rt = seed[5:0] | 6'h15;
            rt[2 * k +: 2] = q;
            @(posedge mclk);
            rates <= rt;
            org <= 4'hC;
            ch <= k[1:0];
            repeat (3 * P2) @(posedge mclk);
            #1 check("rate", srate, q);
            pulses(e - 1, e + 1);
        end
        @(posedge mclk);
        rates <= 6'h3C;
        org <= 4'h4;
        repeat (P2) @(posedge mclk);
        #1 check("route", {act, sref}, {3'h1, 4'h4});
        pulses(0, 0);
        tally_and_finish;
    end
    initial begin
        repeat (40000) @(posedge mclk);
        mismatches = mismatches + 1;
        tally_and_finish;
    end
endmodule // fsis_top_test
